/* File: src/flash_pkg.sv */
// shared constants and types for the row flash self-programming controller
// assumes a single 100 MHz clock and an APB register port with 32-bit data
package flash_pkg;

  localparam int unsigned PADDR_W = 12;

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADDR_LOW = 12'h004;
  localparam logic [11:0] OFS_ADDR_UPPER = 12'h008;
  localparam logic [11:0] OFS_KEY = 12'h00C;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  localparam int unsigned ROW_INSTR = 32;
  localparam int unsigned ROW_BYTES = 96;
  localparam int unsigned PANEL_ROWS = 128;
  localparam int unsigned INSTR_W = 24;
  localparam int unsigned ROW_IDX_W = 5;
  // one instruction spans two address units, so a row spans 64
  localparam int unsigned ROW_ADDR_LSB = 6;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OP_TIME_NS = 2000000;
  localparam int unsigned OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TW_CYCLES = 2;

  localparam logic [3:0] OP_ROW = 4'h1;
  localparam logic [1:0] MEM_PROG_FLASH = 2'h0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;

  typedef struct packed {
    logic start;
    logic write_enable_bit;
    logic [6:0] spare;
    logic erase;
    logic [1:0] mem_sel;
    logic [3:0] op;
  } ctrl_s;

  typedef struct packed {
    logic high;
    logic [23:0] ea;
    logic [15:0] data;
  } tw_req_s;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_state_e;

endpackage

/* File: src/row_latch_bank.sv */
// one panel's write latches: a row of instructions held in flip-flops
// assumes single-cycle write strobes from the sequencer on the same clock
`timescale 1ns/1ps
`default_nettype none
module row_latch_bank #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WORD_W = 24,
  parameter int unsigned IDX_W = 5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WORD_W-1:0] rd_word
);

  logic [WORD_W-1:0] mem_q [DEPTH];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge mclk) begin
        if (rst) begin
          mem_q[i] <= flash_pkg::ERASED_WORD;
        end else if (wr_idx == IDX_W'(i)) begin
          if (wr_low) begin
            mem_q[i][15:0] <= wr_data;
          end
          if (wr_high) begin
            // upper byte of the source word is dropped
            mem_q[i][23:16] <= wr_data[7:0];
          end
        end
      end
    end
  endgenerate

  assign rd_word = mem_q[rd_idx];

endmodule
`default_nettype wire

/* File: src/row_flash_self_programmer.sv */
// row erase / row program sequencer with key unlock and apb registers
// assumes the cpu issues table writes on the same clock and stalls on stall_q
// Overview of operation
// - rows of 32 instructions, 128 rows per panel
// - erase one row, program 32 instructions
// - panel latches hold 32 instructions before programming
// - table write finishes in two cycles
// - low address captures table EA bits 15:0
// - upper address captures table EA bits 23:16
// - software may write both address registers directly
// - key is write-only, 0x55 then 0xAA
// - start bit launches, self-clears at finish
// - operation lasts 2 ms, cpu stalled throughout
// - program sequence starts by key and start bit
// - control selects erase, memory type, start
// - high-byte write uses low data byte only
// - low write bits 15:0, high bits 23:16
`timescale 1ns/1ps
`default_nettype none
module row_flash_self_programmer #(
  parameter int unsigned OP_TICKS = flash_pkg::OP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flash_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tw_valid,
  input wire flash_pkg::tw_req_s tw_req,
  output logic tw_ready,
  output logic stall,
  output logic flash_erase,
  output logic flash_prog,
  output logic [23:0] flash_row_addr,
  output logic [flash_pkg::ROW_IDX_W-1:0] flash_word_idx,
  output logic [flash_pkg::INSTR_W-1:0] flash_word
);

  localparam int unsigned CNT_W = $clog2(OP_TICKS + 1);
  localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(OP_TICKS - 1);
  localparam logic [1:0] TW_LAST = 2'(flash_pkg::TW_CYCLES - 1);

  flash_pkg::ctrl_s ctrl_q;
  logic [15:0] addr_low_q;
  logic [7:0] addr_upper_q;
  flash_pkg::key_state_e key_q;
  logic [CNT_W-1:0] op_cnt_q;
  logic [1:0] tw_cnt_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic tw_ready_q;
  logic stall_q;
  logic erase_q;
  logic prog_q;
  logic [23:0] row_addr_q;
  logic [flash_pkg::ROW_IDX_W-1:0] word_idx_q;
  logic [flash_pkg::INSTR_W-1:0] word_q;
  logic stream_q;

  logic apb_setup;
  logic apb_done;
  logic apb_wr;
  logic tw_done;
  logic start_ok;
  logic busy;
  logic [flash_pkg::INSTR_W-1:0] latch_word;
  flash_pkg::ctrl_s wr_ctrl;

  function automatic logic mapped(input logic [flash_pkg::PADDR_W-1:0] a);
    mapped = (a == flash_pkg::OFS_CTRL) || (a == flash_pkg::OFS_ADDR_LOW) ||
             (a == flash_pkg::OFS_ADDR_UPPER) || (a == flash_pkg::OFS_KEY);
  endfunction

  // row base: clear the in-row instruction bits
  function automatic logic [23:0] row_base(input logic [23:0] ea);
    row_base = {ea[23:flash_pkg::ROW_ADDR_LSB], {flash_pkg::ROW_ADDR_LSB{1'b0}}};
  endfunction

  assign busy = ctrl_q.start;
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && pready_q;
  assign apb_wr = apb_done && pwrite && !pslverr_q;
  assign tw_done = tw_valid && !tw_ready_q && !busy && (tw_cnt_q == TW_LAST);
  assign wr_ctrl = flash_pkg::ctrl_s'(pwdata[15:0]);
  assign start_ok = apb_wr && (paddr == flash_pkg::OFS_CTRL) && wr_ctrl.start && !busy &&
                    wr_ctrl.write_enable_bit && (key_q == flash_pkg::KEY_ARMED) &&
                    (wr_ctrl.op == flash_pkg::OP_ROW) &&
                    (wr_ctrl.mem_sel == flash_pkg::MEM_PROG_FLASH);

  // apb slave: ready raised after setup gives zero wait states
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (apb_setup) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped(paddr);
      prdata_q <= 32'h00000000;
      if (!pwrite) begin
        case (paddr)
          flash_pkg::OFS_CTRL: prdata_q <= {16'h0000, ctrl_q};
          flash_pkg::OFS_ADDR_LOW: prdata_q <= {16'h0000, addr_low_q};
          flash_pkg::OFS_ADDR_UPPER: prdata_q <= {24'h000000, addr_upper_q};
          default: prdata_q <= 32'h00000000; // key reads as zero
        endcase
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // control register and operation timer
  // writes while busy are dropped whole; software polls the start bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= flash_pkg::ctrl_s'(flash_pkg::CTRL_RESET);
      op_cnt_q <= '0;
    end else if (busy) begin
      if (op_cnt_q == OP_LAST) begin
        ctrl_q.start <= 1'b0;
        op_cnt_q <= '0;
      end else begin
        op_cnt_q <= op_cnt_q + CNT_W'(1);
      end
    end else if (apb_wr && paddr == flash_pkg::OFS_CTRL) begin
      ctrl_q <= wr_ctrl;
      ctrl_q.start <= start_ok;
    end
  end

  // address capture from table writes or direct software writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_low_q <= 16'h0000;
      addr_upper_q <= 8'h00;
    end else if (tw_done) begin
      addr_low_q <= tw_req.ea[15:0];
      addr_upper_q <= tw_req.ea[23:16];
    end else if (apb_wr && paddr == flash_pkg::OFS_ADDR_LOW) begin
      addr_low_q <= pwdata[15:0];
    end else if (apb_wr && paddr == flash_pkg::OFS_ADDR_UPPER) begin
      addr_upper_q <= pwdata[7:0];
    end
  end

  // unlock keys: any other mapped register write in between disarms
  always_ff @(posedge mclk) begin
    if (rst) begin
      key_q <= flash_pkg::KEY_IDLE;
    end else if (tw_done) begin
      key_q <= flash_pkg::KEY_IDLE;
    end else if (apb_wr) begin
      if (paddr == flash_pkg::OFS_KEY && pwdata[7:0] == flash_pkg::KEY_FIRST) begin
        key_q <= flash_pkg::KEY_HALF;
      end else if (paddr == flash_pkg::OFS_KEY && pwdata[7:0] == flash_pkg::KEY_SECOND &&
                   key_q == flash_pkg::KEY_HALF) begin
        key_q <= flash_pkg::KEY_ARMED;
      end else begin
        key_q <= flash_pkg::KEY_IDLE;
      end
    end
  end

  // table write: latch-only, so a fixed two-cycle completion
  // a request held across an operation start restarts its count
  always_ff @(posedge mclk) begin
    if (rst) begin
      tw_cnt_q <= 2'h0;
      tw_ready_q <= 1'b0;
    end else if (tw_done) begin
      tw_cnt_q <= 2'h0;
      tw_ready_q <= 1'b1;
    end else begin
      tw_ready_q <= 1'b0;
      if (tw_valid && !tw_ready_q && !busy) begin
        tw_cnt_q <= tw_cnt_q + 2'h1;
      end else begin
        tw_cnt_q <= 2'h0;
      end
    end
  end

  // flash array drive; the cpu is held for the whole operation
  always_ff @(posedge mclk) begin
    if (rst) begin
      stall_q <= 1'b0;
      erase_q <= 1'b0;
      prog_q <= 1'b0;
      row_addr_q <= 24'h000000;
    end else if (start_ok) begin
      stall_q <= 1'b1;
      erase_q <= wr_ctrl.erase;
      prog_q <= !wr_ctrl.erase;
      row_addr_q <= row_base({addr_upper_q, addr_low_q});
    end else if (busy && op_cnt_q == OP_LAST) begin
      stall_q <= 1'b0;
      erase_q <= 1'b0;
      prog_q <= 1'b0;
    end
  end

  // program streams the whole latch row out once, word 0 first
  always_ff @(posedge mclk) begin
    if (rst) begin
      stream_q <= 1'b0;
      word_idx_q <= '0;
      word_q <= flash_pkg::ERASED_WORD;
    end else if (start_ok && !wr_ctrl.erase) begin
      stream_q <= 1'b1;
      word_idx_q <= '0;
    end else if (stream_q) begin
      word_q <= latch_word;
      word_idx_q <= word_idx_q + flash_pkg::ROW_IDX_W'(1);
      if (word_idx_q == flash_pkg::ROW_IDX_W'(flash_pkg::ROW_INSTR - 1)) begin
        stream_q <= 1'b0;
      end
    end
  end

  row_latch_bank #(
    .DEPTH(flash_pkg::ROW_INSTR),
    .WORD_W(flash_pkg::INSTR_W),
    .IDX_W(flash_pkg::ROW_IDX_W)
  ) u_latches (
    .mclk(mclk),
    .rst(rst),
    .wr_low(tw_done && !tw_req.high),
    .wr_high(tw_done && tw_req.high),
    .wr_idx(tw_req.ea[flash_pkg::ROW_IDX_W:1]),
    .wr_data(tw_req.data),
    .rd_idx(word_idx_q),
    .rd_word(latch_word)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tw_ready = tw_ready_q;
  assign stall = stall_q;
  assign flash_erase = erase_q;
  assign flash_prog = prog_q;
  assign flash_row_addr = row_addr_q;
  assign flash_word_idx = word_idx_q;
  assign flash_word = word_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_start_needs_key: assert property ($rose(ctrl_q.start) |->
    $past(key_q) == flash_pkg::KEY_ARMED) else $error("start without unlock keys");
  chk_start_needs_write_enable_bit: assert property ($rose(ctrl_q.start) |->
    ctrl_q.write_enable_bit) else $error("start without write enable");
  chk_op_length: assert property ($fell(ctrl_q.start) |->
    $past(op_cnt_q) == OP_LAST) else $error("operation length wrong");
  chk_stall_with_start: assert property ($rose(stall_q) |->
    stall_q [*8] ##1 (stall_q == ctrl_q.start)) else $error("stall dropped early");
  chk_tw_two_cycles: assert property ($rose(tw_ready_q) |->
    $past(tw_valid, 1) && $past(tw_valid, 2)) else $error("table write not two cycles");
  chk_addr_capture: assert property (tw_ready_q |->
    {addr_upper_q, addr_low_q} == $past(tw_req.ea)) else $error("address not captured");
  chk_row_aligned: assert property ((flash_erase || flash_prog) |->
    flash_row_addr[5:0] == 6'h00) else $error("row address not aligned");
  chk_key_disarm: assert property ((apb_wr && paddr == flash_pkg::OFS_ADDR_LOW) |=>
    key_q == flash_pkg::KEY_IDLE) else $error("key state survived other write");
  chk_no_tw_busy: assert property (stall_q |-> !tw_ready_q)
    else $error("table write done during operation");
  chk_direct_addr: assert property ((apb_wr && paddr == flash_pkg::OFS_ADDR_UPPER) |=>
    addr_upper_q == $past(pwdata[7:0])) else $error("upper address write lost");
  chk_ctrl_frozen_busy: assert property ((busy && apb_wr && op_cnt_q != OP_LAST &&
    paddr == flash_pkg::OFS_CTRL) |=> ctrl_q == $past(ctrl_q))
    else $error("control changed while busy");
  chk_stream_length: assert property ($fell(stream_q) |->
    $past(word_idx_q) == flash_pkg::ROW_IDX_W'(flash_pkg::ROW_INSTR - 1))
    else $error("row stream length wrong");
  chk_low_direct: assert property ((apb_wr && !tw_done &&
    paddr == flash_pkg::OFS_ADDR_LOW) |=> addr_low_q == $past(pwdata[15:0]))
    else $error("low address write lost");
  chk_key_reads_zero: assert property ((apb_setup && !pwrite &&
    paddr == flash_pkg::OFS_KEY) |=> prdata_q == 32'h00000000) else $error("key readable");
  chk_erase_no_stream: assert property (erase_q |-> !stream_q)
    else $error("erase streamed latch data");
  chk_row_addr_hold: assert property ((stall_q && $past(stall_q)) |-> $stable(row_addr_q))
    else $error("row address moved during operation");

  cov_erase: cover property ($rose(flash_erase));
  cov_program: cover property ($rose(flash_prog));
  cov_tw_done: cover property (tw_ready_q);
  cov_op_end: cover property ($fell(stall_q));
  cov_refused_start: cover property (apb_wr && paddr == flash_pkg::OFS_CTRL && wr_ctrl.start && !start_ok);

endmodule
`default_nettype wire

/* File: testbench/cpu_core_model.sv */
// cpu core model: issues table writes into the panel write latches
// assumes the two-cycle table-write handshake of the flash programmer
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic mclk,
  input wire logic tw_ready,
  input wire logic stall,
  output logic tw_valid,
  output var flash_pkg::tw_req_s tw_req
);
  int wait_edges;
  int n_timeout;

  initial begin
    tw_valid = 1'b0;
    tw_req = '0;
    wait_edges = 0;
    n_timeout = 0;
  end

  // request held until ready; stalled cycles simply lengthen the wait
  task automatic table_write(input logic high, input logic [23:0] ea, input logic [15:0] data);
    // a stalled cpu issues nothing until the operation ends
    wait_edges = 0;
    do begin
      @(posedge mclk);
      wait_edges++;
    end while (stall === 1'b1 && wait_edges < 1000);
    tw_valid <= 1'b1;
    tw_req <= '{high: high, ea: ea, data: data};
    wait_edges = 0;
    do begin
      @(posedge mclk);
      wait_edges++;
    end while (tw_ready !== 1'b1 && wait_edges < 1000);
    if (tw_ready !== 1'b1) n_timeout++;
    tw_valid <= 1'b0;
    // released fields show the inverse so a stale request is never reused
    tw_req <= ~{high, ea, data};
  endtask
endmodule
`default_nettype wire

/* File: testbench/row_flash_self_programmer_tb.sv */
// self-checking bench for the row flash self-programming controller
// assumes the apb master here and the cpu core model on the table-write port
`timescale 1ns/1ps
`default_nettype none
module row_flash_self_programmer_tb;
  localparam int unsigned TICKS = 40;
  logic mclk = 1'b0;
  logic rst, psel, penable, pwrite, pready, pslverr, tw_valid, tw_ready, stall;
  logic flash_erase, flash_prog, prev_prog;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, hit;
  logic err;
  logic [23:0] flash_row_addr, flash_word;
  logic [4:0] flash_word_idx, prev_idx;
  logic [23:0] exp_word [32];
  flash_pkg::tw_req_s tw_req;
  int n_mismatch = 0;
  int tests_run = 0;
  int stall_cnt, erase_cnt, prog_cnt;

  always #5 mclk = ~mclk;

  row_flash_self_programmer #(.OP_TICKS(TICKS)) u_dut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tw_valid(tw_valid), .tw_req(tw_req), .tw_ready(tw_ready),
    .stall(stall), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_row_addr(flash_row_addr), .flash_word_idx(flash_word_idx),
    .flash_word(flash_word)
  );

  cpu_core_model u_cpu (
    .mclk(mclk), .tw_ready(tw_ready), .stall(stall), .tw_valid(tw_valid), .tw_req(tw_req)
  );

  // word stream lags the index by one cycle
  always @(posedge mclk) begin
    if (stall === 1'b1) stall_cnt++;
    if (flash_erase === 1'b1) erase_cnt++;
    if (flash_prog === 1'b1) prog_cnt++;
    if (prev_prog && flash_word === exp_word[prev_idx]) hit[prev_idx] = 1'b1;
    prev_prog = (flash_prog === 1'b1);
    prev_idx = flash_word_idx;
  end

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    if (n >= 20) begin
      n_mismatch++;
      conclude();
    end
  endtask

  // clearing go puts a foreign write between the two keys
  task automatic launch(input logic [31:0] c, input logic go, input logic [23:0] row);
    stall_cnt = 0;
    erase_cnt = 0;
    prog_cnt = 0;
    apb(1'b1, flash_pkg::OFS_KEY, {24'h000000, flash_pkg::KEY_FIRST});
    if (!go) apb(1'b1, flash_pkg::OFS_ADDR_UPPER, 32'h00000012);
    apb(1'b1, flash_pkg::OFS_KEY, {24'h000000, flash_pkg::KEY_SECOND});
    apb(1'b1, flash_pkg::OFS_CTRL, c);
    repeat (2) @(posedge mclk);
    if (go) apb(1'b1, flash_pkg::OFS_CTRL, 32'h0);
    apb(1'b0, flash_pkg::OFS_CTRL, 32'h0);
    check(rd, go ? c : (c & 32'h00007FFF), "control while busy");
    if (go) check({8'h00, flash_row_addr}, {8'h00, row}, "row base");
    repeat (TICKS) @(posedge mclk);
    apb(1'b0, flash_pkg::OFS_CTRL, 32'h0);
    check(rd, c & 32'h00007FFF, "control after op");
    check(stall_cnt, go ? TICKS : 0, "stall cycles");
    check(c[6] ? erase_cnt : prog_cnt, go ? TICKS : 0, "op cycles");
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'hFFFFFFFF);
      check(rd, 32'h0, "reset value");
    end
    apb(1'b1, 12'h010, 32'h0000FFFF);
    check({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 12'h010, 32'h0);
    check({rd[30:0], err}, 32'h1, "unmapped read");
  endtask

  // armed keys but no write enable, wrong memory, wrong operation
  task automatic t_refuse();
    logic [31:0] bad [3];
    bad[0] = 32'h00008041;
    bad[1] = 32'h0000C051;
    bad[2] = 32'h0000C042;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, flash_pkg::OFS_KEY, {24'h000000, flash_pkg::KEY_FIRST});
      apb(1'b1, flash_pkg::OFS_KEY, {24'h000000, flash_pkg::KEY_SECOND});
      apb(1'b1, flash_pkg::OFS_CTRL, bad[i]);
      apb(1'b0, flash_pkg::OFS_CTRL, 32'h0);
      check(rd, bad[i] & 32'h00007FFF, "refused start");
      check({31'h0, stall}, 32'h0, "no stall on refusal");
    end
  endtask

  task automatic t_erase();
    apb(1'b1, flash_pkg::OFS_ADDR_UPPER, 32'h00000012);
    apb(1'b1, flash_pkg::OFS_ADDR_LOW, 32'h00003456);
    apb(1'b0, flash_pkg::OFS_ADDR_LOW, 32'h0);
    check(rd, 32'h00003456, "direct low address");
    apb(1'b1, flash_pkg::OFS_CTRL, 32'h00004041);
    launch(32'h0000C041, 1'b0, 24'h123440);
    launch(32'h0000C041, 1'b1, 24'h123440);
  endtask

  task automatic t_program();
    logic [7:0] i8;
    hit = '0;
    for (int i = 0; i < 32; i++) begin
      i8 = 8'(i);
      exp_word[i] = {8'h30 + i8, 8'hC0, i8};
      u_cpu.table_write(1'b0, 24'h011000 + 24'(2 * i), {8'hC0, i8});
      if (i == 0) check(32'(u_cpu.wait_edges), 32'h3, "table write cycles");
      u_cpu.table_write(1'b1, 24'h011000 + 24'(2 * i), {8'hA5, 8'h30 + i8});
      if (u_cpu.n_timeout != 0) begin
        n_mismatch++;
        conclude();
      end
    end
    apb(1'b0, flash_pkg::OFS_ADDR_LOW, 32'h0);
    check(rd, 32'h0000103E, "captured low address");
    apb(1'b0, flash_pkg::OFS_ADDR_UPPER, 32'h0);
    check(rd, 32'h00000001, "captured upper address");
    apb(1'b1, flash_pkg::OFS_CTRL, 32'h00004001);
    launch(32'h0000C001, 1'b1, 24'h011000);
    check(hit, 32'hFFFFFFFF, "streamed row");
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    prev_prog = 1'b0;
    prev_idx = 5'h00;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_refuse();
    t_erase();
    t_program();
    conclude();
  end
endmodule
`default_nettype wire
